// *** lis_pkg.sv ***
package lis_pkg;
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_LEVEL  = 8'h04;
	localparam logic [7:0] OFS_DISC   = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_SIMLVL = 8'h10;
	localparam logic [7:0] OFS_LOGCTL = 8'h14;
	localparam logic [7:0] OFS_ALARM  = 8'h18;
	localparam logic [7:0] OFS_PUMPDL = 8'h1C;
	localparam logic [7:0] OFS_SAMPLE = 8'h20;
	// Control field positions
	localparam int CTRL_LVL_EN  = 0;
	localparam int CTRL_RAMP_EN = 1;
	localparam int CTRL_PUMP_EN = 2;
	localparam int CTRL_RATE_LO = 4;
	// Reset values
	localparam logic [15:0] LEVEL_RST  = 16'h0000;
	localparam logic [15:0] ALARM_RST  = 16'hFFFF;
	localparam logic [15:0] PUMPDL_RST = 16'h0000;
	localparam logic [15:0] SAMPLE_RST = 16'h0000;
	// Full scale of the level, 100.00 percent
	localparam logic [15:0] LEVEL_FULL = 16'h2710;
	// Ramp steps per millisecond tick
	localparam logic [15:0] STEP_SLOW = 16'h0001;
	localparam logic [15:0] STEP_MED  = 16'h000A;
	localparam logic [15:0] STEP_FAST = 16'h0064;
	// Timing
	localparam int CLK_MHZ       = 100;
	localparam int TICK_US       = 1000;
	localparam int TICK_CYCLES   = TICK_US * CLK_MHZ;
	localparam int TIMEOUT_MIN   = 10;
	localparam int TIMEOUT_TICKS = TIMEOUT_MIN * 60 * 1000;
	// Input simulation setting
	typedef enum logic [1:0] {
		DI_DISABLED = 2'b00,
		DI_OFF      = 2'b01,
		DI_ON       = 2'b10
	} lis_dimode_t;
	// Pins from the field, asynchronous
	typedef struct packed {
		logic [15:0] measLevel;
		logic [1:0]  discIn;
		logic        faultIn;
		logic        logFullIn;
		logic        filesRemoved;
	} lis_pins_t;
	// Registered results towards the instrument
	typedef struct packed {
		logic [15:0] procLevel;
		logic [1:0]  discEff;
		logic        backupOvr;
		logic        alarmHigh;
		logic        failSafe;
		logic        flowTotEn;
		logic        pumpTotEn;
		logic        pumpInd;
		logic        pumpRelay;
		logic        simMsg;
		logic        remoteSim;
		logic        logFault;
	} lis_out_t;
endpackage

// *** lis_sim_ctrl.sv ***
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module lis_sim_ctrl
	import lis_pkg::*;
#(
	parameter int TICK_DIV  = TICK_CYCLES,
	parameter int TIMEOUT_T = TIMEOUT_TICKS
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wrStb,
	input  wire logic        rdStb,
	output logic      [31:0] rdata,
	// Field pins and pump logic
	input  wire lis_pins_t   pins,
	input  wire logic        pumpDemand,
	// Results
	output lis_out_t         outs,
	output logic             samplePulse
);
	// Synchroniser stages; stage one read only by stage two
	lis_pins_t   pinS1_reg;
	lis_pins_t   pinS2_reg;
	logic        removedD_reg;     // Edge detect on synced removal
	// Software registers
	logic        lvlEn_reg;
	logic        rampEn_reg;
	logic        pumpAct_reg;
	logic [1:0]  rateSel_reg;
	logic [15:0] levelVal_reg;
	lis_dimode_t diMode_reg [2];
	logic        logEn_reg;
	logic [15:0] alarmSp_reg;
	logic [15:0] pumpDly_reg;
	logic [15:0] sampleIv_reg;
	// Block state
	logic [15:0] simLevel_reg;
	logic        rampUp_reg;       // Ramp direction, high rising
	logic        lvlEnD_reg;       // Enable from last cycle
	logic        logFault_reg;
	logic [31:0] tickCnt_reg;
	logic        tick;
	logic [31:0] toCnt_reg;        // Timeout counter in ticks
	logic        timeoutHit;
	logic        pumpRun_reg;
	logic [15:0] gapCnt_reg;       // Pump start gap remaining
	logic [15:0] sampCnt_reg;
	// Decoded conditions
	logic        wrCtrl;
	logic        wrDisc;
	logic        simActive;
	logic        diSim;
	logic        removedEdge;
	logic [15:0] step;
	logic [1:0]  discEff;

	// Step size from rate selection
	function automatic logic [15:0] rateStep(input logic [1:0] sel);
		case (sel)
			2'b00:   rateStep = STEP_SLOW;
			2'b01:   rateStep = STEP_MED;
			default: rateStep = STEP_FAST;
		endcase
	endfunction

	// Forced or real input state
	function automatic logic diPick(input lis_dimode_t m, input logic real_in);
		case (m)
			DI_ON:   diPick = 1'b1;
			DI_OFF:  diPick = 1'b0;
			default: diPick = real_in;
		endcase
	endfunction

	assign wrCtrl      = wrStb && (addr == OFS_CTRL);
	assign wrDisc      = wrStb && (addr == OFS_DISC);
	assign diSim       = (diMode_reg[0] != DI_DISABLED) || (diMode_reg[1] != DI_DISABLED);
	assign simActive   = lvlEn_reg || diSim;
	assign removedEdge = pinS2_reg.filesRemoved && !removedD_reg;
	assign step        = rateStep(rateSel_reg);
	assign tick        = (tickCnt_reg == 32'(TICK_DIV - 1));
	assign timeoutHit  = tick && simActive && (toCnt_reg == 32'(TIMEOUT_T - 1));
	assign discEff[0]  = diPick(diMode_reg[0], pinS2_reg.discIn[0]);
	assign discEff[1]  = diPick(diMode_reg[1], pinS2_reg.discIn[1]);

	// Two-flop synchroniser for all field pins
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pinS1_reg    <= '0;
			pinS2_reg    <= '0;
			removedD_reg <= 1'b0;
		end else begin
			pinS1_reg    <= pins;
			pinS2_reg    <= pinS1_reg;
			removedD_reg <= pinS2_reg.filesRemoved;
		end
	end

	// Millisecond tick divider
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tickCnt_reg <= '0;
		end else if (tick) begin
			tickCnt_reg <= '0;
		end else begin
			tickCnt_reg <= tickCnt_reg + 32'h0000_0001;
		end
	end

	// Simulation enables; a write in the timeout cycle wins
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lvlEn_reg   <= 1'b0;
			rampEn_reg  <= 1'b0;
			pumpAct_reg <= 1'b0;
			rateSel_reg <= 2'b00;
		end else if (wrCtrl) begin
			// Clearing the enable stops at once
			lvlEn_reg   <= wdata[CTRL_LVL_EN];
			rampEn_reg  <= wdata[CTRL_RAMP_EN];
			pumpAct_reg <= wdata[CTRL_PUMP_EN];
			rateSel_reg <= wdata[CTRL_RATE_LO +: 2];
		end else if (timeoutHit) begin
			lvlEn_reg   <= 1'b0;
			pumpAct_reg <= 1'b0;
		end
	end

	// Input simulation settings; reserved code reads as disabled
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			diMode_reg[0] <= DI_DISABLED;
			diMode_reg[1] <= DI_DISABLED;
		end else if (wrDisc) begin
			diMode_reg[0] <= (wdata[1:0] == 2'b11) ? DI_DISABLED : lis_dimode_t'(wdata[1:0]);
			diMode_reg[1] <= (wdata[3:2] == 2'b11) ? DI_DISABLED : lis_dimode_t'(wdata[3:2]);
		end else if (timeoutHit) begin
			diMode_reg[0] <= DI_DISABLED;
			diMode_reg[1] <= DI_DISABLED;
		end
	end

	// Plain settings; level value edits do not restart the timer
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			levelVal_reg <= LEVEL_RST;
			logEn_reg    <= 1'b0;
			alarmSp_reg  <= ALARM_RST;
			pumpDly_reg  <= PUMPDL_RST;
			sampleIv_reg <= SAMPLE_RST;
		end else if (wrStb) begin
			case (addr)
				OFS_LEVEL:  levelVal_reg <= (wdata[15:0] > LEVEL_FULL) ? LEVEL_FULL : wdata[15:0];
				OFS_LOGCTL: logEn_reg    <= wdata[0];
				OFS_ALARM:  alarmSp_reg  <= wdata[15:0];
				OFS_PUMPDL: pumpDly_reg  <= wdata[15:0];
				OFS_SAMPLE: sampleIv_reg <= wdata[15:0];
				default:    ;
			endcase
		end
	end

	// Inactivity timer; restarts on a control or input setting write
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			toCnt_reg <= '0;
		end else if (wrCtrl || wrDisc || !simActive || timeoutHit) begin
			toCnt_reg <= '0;
		end else if (tick) begin
			toCnt_reg <= toCnt_reg + 32'h0000_0001;
		end
	end

	// Simulated level: hold or bounce between the ends
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			simLevel_reg <= LEVEL_RST;
			rampUp_reg   <= 1'b1;
			lvlEnD_reg   <= 1'b0;
		end else begin
			lvlEnD_reg <= lvlEn_reg;
			if (!lvlEn_reg || !rampEn_reg || !lvlEnD_reg) begin
				// Fixed level, and the start point of any ramp
				simLevel_reg <= levelVal_reg;
				rampUp_reg   <= 1'b1;
			end else if (tick) begin
				if (rampUp_reg) begin
					if (simLevel_reg >= LEVEL_FULL - step) begin
						simLevel_reg <= LEVEL_FULL;
						rampUp_reg   <= 1'b0;
					end else begin
						simLevel_reg <= simLevel_reg + step;
					end
				end else begin
					if (simLevel_reg <= step) begin
						simLevel_reg <= 16'h0000;
						rampUp_reg   <= 1'b1;
					end else begin
						simLevel_reg <= simLevel_reg - step;
					end
				end
			end
		end
	end

	// Log-full fault; setting outranks a removal in the same cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			logFault_reg <= 1'b0;
		end else if (pinS2_reg.logFullIn) begin
			logFault_reg <= 1'b1;
		end else if (removedEdge && !logEn_reg) begin
			logFault_reg <= 1'b0;
		end
	end

	// Pump start gate; the gap applies in every mode
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pumpRun_reg <= 1'b0;
			gapCnt_reg  <= '0;
		end else begin
			if (!pumpDemand) begin
				pumpRun_reg <= 1'b0;
			end else if (!pumpRun_reg && gapCnt_reg == 16'h0000) begin
				pumpRun_reg <= 1'b1;
			end
			if (pumpDemand && !pumpRun_reg && gapCnt_reg == 16'h0000) begin
				gapCnt_reg <= pumpDly_reg;
			end else if (tick && gapCnt_reg != 16'h0000) begin
				gapCnt_reg <= gapCnt_reg - 16'h0001;
			end
		end
	end

	// External sampler, unaffected by simulation
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sampCnt_reg <= '0;
			samplePulse <= 1'b0;
		end else begin
			samplePulse <= 1'b0;
			if (sampleIv_reg == 16'h0000) begin
				sampCnt_reg <= '0;
			end else if (tick) begin
				if (sampCnt_reg >= sampleIv_reg - 16'h0001) begin
					sampCnt_reg <= '0;
					samplePulse <= 1'b1;
				end else begin
					sampCnt_reg <= sampCnt_reg + 16'h0001;
				end
			end
		end
	end

	// Results to loop, alarms, log, relays and remote link
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			outs <= '0;
		end else begin
			// One level feeds loop, alarm, log and remote values
			outs.procLevel <= lvlEn_reg ? simLevel_reg : pinS2_reg.measLevel;
			outs.alarmHigh <= (lvlEn_reg ? simLevel_reg
				: pinS2_reg.measLevel) >= alarmSp_reg;
			outs.discEff   <= discEff;
			// Backup override looks only at the input, never the level
			outs.backupOvr <= discEff[0];
			outs.failSafe  <= pinS2_reg.faultIn && !simActive;
			outs.flowTotEn <= !simActive;
			outs.pumpTotEn <= !simActive || pumpAct_reg;
			outs.pumpInd   <= pumpRun_reg;
			outs.pumpRelay <= pumpRun_reg && (!simActive || pumpAct_reg);
			outs.simMsg    <= simActive;
			outs.remoteSim <= simActive;
			outs.logFault  <= logFault_reg;
		end
	end

	// Read data, valid the cycle after the strobe only
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= '0;
		end else if (rdStb) begin
			case (addr)
				OFS_CTRL:   rdata <= {26'h0, rateSel_reg, 1'b0, pumpAct_reg,
					rampEn_reg, lvlEn_reg};
				OFS_LEVEL:  rdata <= {16'h0000, levelVal_reg};
				OFS_DISC:   rdata <= {28'h0, diMode_reg[1], diMode_reg[0]};
				OFS_STATUS: rdata <= {26'h0, rampUp_reg, outs.failSafe, logFault_reg,
					diSim, lvlEn_reg, simActive};
				OFS_SIMLVL: rdata <= {16'h0000, simLevel_reg};
				OFS_LOGCTL: rdata <= {31'h0, logEn_reg};
				OFS_ALARM:  rdata <= {16'h0000, alarmSp_reg};
				OFS_PUMPDL: rdata <= {16'h0000, pumpDly_reg};
				OFS_SAMPLE: rdata <= {16'h0000, sampleIv_reg};
				default:    rdata <= '0;
			endcase
		end else begin
			rdata <= '0;
		end
	end

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	AST_LOGFULL_SET: assert property (pinS2_reg.logFullIn |=> ##1 outs.logFault)
		else $error("log fault not raised");
	AST_LOGFULL_HOLD: assert property ((logFault_reg && logEn_reg) |=> logFault_reg)
		else $error("log fault cleared while logging enabled");
	AST_RAMP_START: assert property ((lvlEn_reg && !lvlEnD_reg) |=> rampUp_reg)
		else $error("ramp does not start rising");
	AST_FIXED_LEVEL: assert property ((lvlEn_reg && !rampEn_reg && !wrStb)
		|=> simLevel_reg == $past(levelVal_reg))
		else $error("fixed level not held");
	AST_RANGE: assert property (simLevel_reg <= LEVEL_FULL)
		else $error("simulated level out of range");
	AST_DI_FORCE: assert property ((diMode_reg[0] == DI_ON && !wrDisc && !timeoutHit)
		|=> ##1 outs.backupOvr)
		else $error("forced input not seen by override");
	AST_NO_FAILSAFE: assert property (simActive |=> !outs.failSafe)
		else $error("fail-safe reported in simulation");
	AST_PUMP_RELAY: assert property ((pumpRun_reg && simActive && !pumpAct_reg)
		|=> outs.pumpInd && !outs.pumpRelay)
		else $error("pump relay energised without permission");
	AST_FLOW_HOLD: assert property (simActive |=> !outs.flowTotEn)
		else $error("flow totalizer enabled in simulation");
	AST_SIM_MSG: assert property ($rose(simActive) |=> outs.simMsg && outs.remoteSim)
		else $error("simulation status missing");
	AST_TIMEOUT: assert property ((timeoutHit && !wrCtrl && !wrDisc)
		|=> !simActive ##1 !outs.simMsg)
		else $error("timeout did not end simulation");

	// Start gap keeps the pump off, simulated or not
	AST_PUMP_GAP: assert property ((!pumpRun_reg && gapCnt_reg != 16'h0000)
		|=> !pumpRun_reg)
		else $error("pump started inside start gap");

	// Override follows input 0 only, never the level
	AST_BACKUP_INPUT: assert property (lvlEn_reg
		|=> outs.backupOvr == $past(discEff[0]))
		else $error("backup override not driven by input");

	// Pumped volume frozen in simulation unless activations allowed
	AST_PUMP_TOT: assert property ((simActive && !pumpAct_reg)
		|=> !outs.pumpTotEn)
		else $error("pumped volume counting in simulation");

	// Interval of one tick clicks on every tick
	AST_SAMPLER: assert property ((tick && sampleIv_reg == 16'h0001)
		|=> samplePulse)
		else $error("sampler pulse missing");

	// Dropping the enable hands back the measured level
	AST_LEVEL_OFF: assert property (!lvlEn_reg
		|=> outs.procLevel == $past(pinS2_reg.measLevel))
		else $error("measured level not restored");

	// Loop, log and remote values take the simulated level
	AST_SIM_LEVEL: assert property (lvlEn_reg
		|=> outs.procLevel == $past(simLevel_reg))
		else $error("loop level not simulated");

	// Forced off input reads inactive downstream
	AST_DI_OFF: assert property ((diMode_reg[1] == DI_OFF)
		|=> !outs.discEff[1])
		else $error("forced off input seen active");

	// Timer held at zero after an edit or with nothing simulated
	AST_TIMER_CLEAR: assert property ((wrCtrl || wrDisc || !simActive)
		|=> toCnt_reg == 32'h0000_0000)
		else $error("timeout counter not restarted");

	// Either simulation on its own is flagged
	AST_MSG_EITHER: assert property ((lvlEn_reg != diSim)
		|=> outs.simMsg && outs.remoteSim)
		else $error("single simulation not flagged");

	COV_REVERSE: cover property (rampUp_reg ##1 !rampUp_reg);
	COV_TIMEOUT: cover property (timeoutHit);
	COV_LOG_CLEAR: cover property (logFault_reg ##1 !logFault_reg);
	COV_BOTH_SIM: cover property (lvlEn_reg && diSim);
	COV_PUMP_GAP: cover property (pumpDemand && !pumpRun_reg && gapCnt_reg != 16'h0000);
endmodule

// *** lis_field_model.sv ***
`timescale 1ns/1ns
module lis_field_model
	import lis_pkg::*;
(
	// Clock
	input  wire logic mclk,
	// Field side
	output lis_pins_t  pins,
	output logic       pumpDemand
);
	// Quiet field at time zero
	initial begin
		pins = '0;
		pumpDemand = 1'b0;
	end

	// Field changes just after an edge; the block syncs the pins, though not pumpDemand
	task automatic drive(input lis_pins_t p, input logic d);
		@(posedge mclk);
		pins <= p;
		pumpDemand <= d;
	endtask

	// Removal held long enough to pass the two sync stages
	task automatic pulseRemove();
		@(posedge mclk);
		pins.filesRemoved <= 1'b1;
		repeat (4) @(posedge mclk);
		pins.filesRemoved <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask
endmodule

// *** lis_sim_ctrl_tb_top.sv ***
`timescale 1ns/1ns
module lis_sim_ctrl_tb_top
	import lis_pkg::*;
;
	logic        mclk;        // System clock
	logic        arst_n;      // Reset, active low
	logic [7:0]  addr;        // Register address
	logic [31:0] wdata;       // Write data
	logic        wrStb;       // Write strobe
	logic        rdStb;       // Read strobe
	logic [31:0] rdata;       // Read data
	lis_pins_t   pins;        // Field pins
	logic        pumpDemand;  // Pump wanted
	lis_out_t    outs;        // Results
	logic        samplePulse; // Sampler click
	lis_pins_t   fp;          // Field state we ask for
	logic [31:0] rv;          // Last read value
	logic [31:0] rv0;         // Earlier read value
	logic [3:0]  dv [5];      // Input setting codes
	logic [1:0]  de [5];      // Expected effective inputs
	int          n_fail;
	int          n_compared;
	int          cyc;
	int          pulses;
	int          i;

	// Short counts keep timeout near 20 cycles
	lis_sim_ctrl #(.TICK_DIV(4), .TIMEOUT_T(5)) i_lis_sim_ctrl (
		.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wrStb(wrStb),
		.rdStb(rdStb), .rdata(rdata), .pins(pins), .pumpDemand(pumpDemand),
		.outs(outs), .samplePulse(samplePulse));

	lis_field_model i_lis_field_model (.mclk(mclk), .pins(pins), .pumpDemand(pumpDemand));

	// Clock, 10 ns period
	initial mclk = 1'b0;
	always #5 mclk = ~mclk;

	// Hang guard, far above the sequence length
	initial cyc = 0;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			finish_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Let edges pass, then look once things settle
	task automatic waitc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wrStb <= 1'b1;
		@(posedge mclk);
		wrStb <= 1'b0;
	endtask

	// Data stand only in the cycle after the strobe
	task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge mclk);
		rdStb <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic finish_test();
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		n_fail = 0;
		n_compared = 0;
		arst_n = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		wrStb = 1'b0;
		rdStb = 1'b0;
		fp = '0;
		fp.measLevel = 16'h0100;
		fp.discIn = 2'b10;
		// Codes: on/off, off/on, both disabled, reserved, on/disabled
		dv = '{4'h6, 4'h9, 4'h0, 4'hF, 4'h2};
		de = '{2'b01, 2'b10, 2'b10, 2'b10, 2'b11};
		i_lis_field_model.drive(fp, 1'b0);
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		// Reset values and an unmapped place
		rdReg(OFS_ALARM, rv); chk("alarm", rv, 32'h0000_FFFF);
		wr(8'h24, 32'h0000_0001);
		rdReg(8'h24, rv); chk("unmapped", rv, 32'h0000_0000);
		rdReg(OFS_CTRL, rv); chk("ctrl", rv, 32'h0000_0000);
		chk("level", 32'(outs.procLevel), 32'h0000_0100);
		// Fixed level with a live fault
		fp.faultIn = 1'b1;
		i_lis_field_model.drive(fp, 1'b0);
		wr(OFS_ALARM, 32'h0000_1000);
		wr(OFS_LEVEL, 32'h0000_1234);
		wr(OFS_CTRL, 32'h0000_0001);
		waitc(5);
		chk("level", 32'(outs.procLevel), 32'h0000_1234);
		chk("alarm", 32'(outs.alarmHigh), 32'h0000_0001);
		chk("failsafe", 32'(outs.failSafe), 32'h0000_0000);
		chk("flowtot", 32'(outs.flowTotEn), 32'h0000_0000);
		chk("msg", 32'(outs.simMsg), 32'h0000_0001);
		chk("remote", 32'(outs.remoteSim), 32'h0000_0001);
		chk("inputs", 32'(outs.discEff), 32'h0000_0002);
		rdReg(OFS_SIMLVL, rv); chk("simlvl", rv, 32'h0000_1234);
		wr(OFS_CTRL, 32'h0000_0000);
		waitc(4);
		chk("level", 32'(outs.procLevel), 32'h0000_0100);
		chk("failsafe", 32'(outs.failSafe), 32'h0000_0001);
		chk("msg", 32'(outs.simMsg), 32'h0000_0000);
		// Input settings beside a full level
		fp.faultIn = 1'b0;
		i_lis_field_model.drive(fp, 1'b0);
		wr(OFS_LEVEL, 32'h0000_2710);
		wr(OFS_CTRL, 32'h0000_0001);
		for (i = 0; i < 5; i++) begin
			wr(OFS_DISC, 32'(dv[i]));
			waitc(4);
			chk("inputs", 32'(outs.discEff), 32'(de[i]));
			chk("override", 32'(outs.backupOvr), 32'(de[i][0]));
		end
		// Pump with relays held off, then allowed, then a start gap
		wr(OFS_PUMPDL, 32'h0000_000A);
		i_lis_field_model.drive(fp, 1'b1);
		waitc(5);
		chk("pumpind", 32'(outs.pumpInd), 32'h0000_0001);
		chk("relay", 32'(outs.pumpRelay), 32'h0000_0000);
		chk("pumptot", 32'(outs.pumpTotEn), 32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_0005);
		waitc(4);
		chk("relay", 32'(outs.pumpRelay), 32'h0000_0001);
		chk("pumptot", 32'(outs.pumpTotEn), 32'h0000_0001);
		i_lis_field_model.drive(fp, 1'b0);
		waitc(3);
		i_lis_field_model.drive(fp, 1'b1);
		waitc(4);
		chk("pumpind", 32'(outs.pumpInd), 32'h0000_0000);
		i_lis_field_model.drive(fp, 1'b0);
		// Timeout ignores level edits and clears the level and pump enables and input settings
		wr(OFS_DISC, 32'h0000_0002);
		waitc(12);
		wr(OFS_LEVEL, 32'h0000_0500);
		waitc(10);
		rdReg(OFS_CTRL, rv); chk("ctrl", rv, 32'h0000_0000);
		rdReg(OFS_DISC, rv); chk("disc", rv, 32'h0000_0000);
		chk("msg", 32'(outs.simMsg), 32'h0000_0000);
		chk("remote", 32'(outs.remoteSim), 32'h0000_0000);
		// A fresh edit restarts the count
		wr(OFS_CTRL, 32'h0000_0001);
		waitc(12);
		wr(OFS_CTRL, 32'h0000_0001);
		waitc(12);
		chk("msg", 32'(outs.simMsg), 32'h0000_0001);
		waitc(20);
		chk("msg", 32'(outs.simMsg), 32'h0000_0000);
		// Ramp near the top must climb, then come back down
		wr(OFS_LEVEL, 32'h0000_2700);
		wr(OFS_CTRL, 32'h0000_0023);
		pulses = 0;
		repeat (12) begin
			waitc(1);
			if (outs.procLevel === 16'h2710)
				pulses = 1;
		end
		chk("top", 32'(pulses), 32'h0000_0001);
		waitc(2);
		chk("down", 32'(outs.procLevel < 16'h2710), 32'h0000_0001);
		rdReg(OFS_STATUS, rv); chk("rising", 32'(rv[5]), 32'h0000_0000);
		// Medium then slow rate: two reads exactly one tick apart
		wr(OFS_CTRL, 32'h0000_0000);
		wr(OFS_LEVEL, 32'h0000_0100);
		wr(OFS_CTRL, 32'h0000_0013);
		for (i = 0; i < 2; i++) begin
			waitc(2);
			rdReg(OFS_SIMLVL, rv0);
			waitc(2);
			rdReg(OFS_SIMLVL, rv);
			chk("step", rv - rv0, 32'(i == 0 ? STEP_MED : STEP_SLOW));
			wr(OFS_CTRL, 32'h0000_0003);
		end
		// Sampler keeps clicking in simulation
		wr(OFS_SAMPLE, 32'h0000_0001);
		wr(OFS_CTRL, 32'h0000_0001);
		pulses = 0;
		repeat (16) begin
			waitc(1);
			if (samplePulse === 1'b1)
				pulses++;
		end
		chk("sampler", 32'(pulses >= 3 && pulses <= 5), 32'h0000_0001);
		wr(OFS_CTRL, 32'h0000_0000);
		// Log full, removal while logging stays set
		fp.logFullIn = 1'b1;
		i_lis_field_model.drive(fp, 1'b0);
		waitc(5);
		chk("logfault", 32'(outs.logFault), 32'h0000_0001);
		fp.logFullIn = 1'b0;
		i_lis_field_model.drive(fp, 1'b0);
		wr(OFS_LOGCTL, 32'h0000_0001);
		i_lis_field_model.pulseRemove();
		chk("logfault", 32'(outs.logFault), 32'h0000_0001);
		wr(OFS_LOGCTL, 32'h0000_0000);
		i_lis_field_model.pulseRemove();
		waitc(2);
		chk("logfault", 32'(outs.logFault), 32'h0000_0000);
		finish_test();
	end
endmodule
